// [esr_bus_partner.sv]
// Bus side model: completes issued data transactions after at least LAT cycles, later while stall is held or others queue
module esr_bus_partner #(
  parameter int LAT = 3
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Transaction flow
  input  wire logic issue,
  input  wire logic stall,
  output logic      done
);
  timeunit 1ns;
  timeprecision 1ps;

  int pendCnt;
  int timer;
  int nextCnt;

  // One completion at a time; stall models a slow slave sitting on its answer
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pendCnt <= 0;
      timer   <= 0;
      done    <= 1'b0;
    end else begin
      nextCnt = pendCnt + (issue ? 1 : 0);
      done <= 1'b0;
      if (nextCnt > 0 && !stall && timer >= LAT) begin
        done <= 1'b1;
        nextCnt = nextCnt - 1;
        timer <= 0;
      end else if (nextCnt > 0) begin
        timer <= timer + 1;
      end
      pendCnt <= nextCnt;
    end
  end
endmodule

// [esr_exception_unit.sv]
// Exception state tracking, barrier ordering and region checks for the core
module esr_exception_unit
  import esr_pkg::*;
#(
  parameter int unsigned NUM_IRQ = 32,
  parameter int unsigned MAX_OUT = 4,
  parameter int unsigned NUM_W   = $clog2(NUM_IRQ + 16)
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  // Instruction fetch check
  input  wire logic               fetchValid,
  input  wire logic [31:0]        fetchAddr,
  output logic                    fetchRefused_reg,
  // Data request from pipeline
  input  wire logic               dataReq,
  input  wire logic [31:0]        dataAddr,
  input  wire logic [1:0]         dataSize,
  input  wire logic               dataWrite,
  input  wire logic [31:0]        dataWdata,
  input  wire logic               dataDone,
  // Data issue toward bus
  output logic                    dataIssue_reg,
  output logic                    dataRefused_reg,
  output logic [31:0]             dataAddrOut_reg,
  output logic [3:0]              dataByteEn_reg,
  output logic [31:0]             dataLaneData_reg,
  output logic                    dataWriteOut_reg,
  // Barriers
  input  wire logic               barrierDmb,
  input  wire logic               barrierDsb,
  input  wire logic               barrierIsb,
  output logic                    pipeStall_reg,
  output logic                    refetch_reg,
  // Exception sources
  input  wire logic [NUM_IRQ-1:0] irqIn,
  input  wire logic [NUM_IRQ-1:0] irqSoftSet,
  input  wire logic               nmiIn,
  input  wire logic               nmiSoftSet,
  input  wire logic               errorEvent,
  input  wire logic               svcExec,
  input  wire logic               pendSvSet,
  input  wire logic               sysTickZero,
  input  wire logic               sysTickSet,
  input  wire logic               excReturn,
  // Priority configuration
  input  wire logic               prioWrite,
  input  wire logic [NUM_W-1:0]   prioExcNum,
  input  wire logic [1:0]         prioValue,
  // Exception status
  output logic                    bootFetch_reg,
  output logic                    excTake_reg,
  output logic [NUM_W-1:0]        excNum_reg,
  output logic [31:0]             excVector_reg,
  output logic                    handlerMode_reg,
  output logic [NUM_IRQ+15:0]     excPend_reg,
  output logic [NUM_IRQ+15:0]     excActive_reg
);

  localparam int EXC_N = NUM_IRQ + 16;
  localparam int CW    = $clog2(MAX_OUT + 1);

  function automatic logic [3:0] laneMask(logic [1:0] size, logic [1:0] off);
    laneMask = (size == SIZE_WORD) ? 4'hf :
               (size == SIZE_HALF) ? 4'(4'h3 << off) : 4'(4'h1 << off);
  endfunction

  function automatic logic isCfgNum(int n);
    isCfgNum = (n == EXC_SVC) || (n == EXC_PENDED_SERVICE_EXCEPTION) || (n == EXC_SYSTEM_TIMER_EXCEPTION) || (n >= EXC_IRQ_BASE && n < EXC_N);
  endfunction

  function automatic logic [31:0] vecOf(logic [NUM_W-1:0] n);
    vecOf = VECTOR_BASE + (32'(n) << 2);
  endfunction

  // Region attributes
  esr_region_t  fetchRegion;
  esr_memtype_t fetchType;
  logic         fetchXnRaw;
  esr_region_t  dataRegion;
  esr_memtype_t dataType;
  logic         dataXn;

  esr_region_decode u_fetchDec (
    .addr      (fetchAddr),
    .region    (fetchRegion),
    .memType   (fetchType),
    .execNever (fetchXnRaw)
  );

  esr_region_decode u_dataDec (
    .addr      (dataAddr),
    .region    (dataRegion),
    .memType   (dataType),
    .execNever (dataXn)
  );

  // Input synchronisers for the asynchronous pins
  logic [NUM_IRQ-1:0] irqMeta_reg;
  logic [NUM_IRQ-1:0] irqSync_reg;
  logic [NUM_IRQ-1:0] irqLast_reg;
  logic               nmiMeta_reg;
  logic               nmiSync_reg;
  logic               nmiLast_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqMeta_reg <= '0;
      irqSync_reg <= '0;
      irqLast_reg <= '0;
      nmiMeta_reg <= 1'b0;
      nmiSync_reg <= 1'b0;
      nmiLast_reg <= 1'b0;
    end else begin
      irqMeta_reg <= irqIn;
      irqSync_reg <= irqMeta_reg;
      irqLast_reg <= irqSync_reg;
      nmiMeta_reg <= nmiIn;
      nmiSync_reg <= nmiMeta_reg;
      nmiLast_reg <= nmiSync_reg;
    end
  end

  wire [NUM_IRQ-1:0] irqEdge = irqSync_reg & ~irqLast_reg;
  wire               nmiEdge = nmiSync_reg & ~nmiLast_reg;

  // Memory ordering and issue
  logic [CW-1:0] outCnt_reg;
  logic [CW-1:0] outCnt_next;
  logic          strongOut_reg;
  logic          dmbWait_reg;

  wire fetchXn    = fetchValid && fetchXnRaw;
  wire isStrong   = (dataType == MEM_STRONG);
  wire narrowPpr  = dataReq && (dataRegion == REG_PPR) && (dataSize != SIZE_WORD);
  wire dataBusy   = dataIssue_reg || dataRefused_reg;
  wire strongGate = !isStrong || (outCnt_reg == '0);
  wire issue      = dataReq && !narrowPpr && !dataBusy && !dmbWait_reg && !strongOut_reg &&
                    strongGate && (outCnt_reg < CW'(MAX_OUT));
  wire hardEvent  = errorEvent || fetchXn || (narrowPpr && !dataBusy);

  assign outCnt_next = outCnt_reg + CW'(issue) - CW'(dataDone);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outCnt_reg    <= '0;
      strongOut_reg <= 1'b0;
      dmbWait_reg   <= 1'b0;
      pipeStall_reg <= 1'b0;
      refetch_reg   <= 1'b0;
    end else begin
      outCnt_reg    <= outCnt_next;
      strongOut_reg <= (issue && isStrong) || (strongOut_reg && outCnt_next != '0);
      dmbWait_reg   <= (barrierDmb || dmbWait_reg) && (outCnt_next != '0);
      pipeStall_reg <= (barrierDsb || pipeStall_reg) && (outCnt_next != '0 || barrierDsb);
      refetch_reg   <= barrierIsb;
    end
  end

  // Little-endian lane placement of the request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchRefused_reg <= 1'b0;
      dataIssue_reg    <= 1'b0;
      dataRefused_reg  <= 1'b0;
      dataAddrOut_reg  <= '0;
      dataByteEn_reg   <= '0;
      dataLaneData_reg <= '0;
      dataWriteOut_reg <= 1'b0;
    end else begin
      fetchRefused_reg <= fetchXn;
      dataIssue_reg    <= issue;
      dataRefused_reg  <= narrowPpr && !dataBusy;
      if (issue) begin
        dataAddrOut_reg  <= dataAddr;
        dataByteEn_reg   <= laneMask(dataSize, dataAddr[1:0]);
        dataLaneData_reg <= dataWdata << {dataAddr[1:0], 3'b000};
        dataWriteOut_reg <= dataWrite;
      end
    end
  end

  // Priority table, reset to zero
  logic [1:0] prioTable_reg [EXC_N];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < EXC_N; i++) begin
        prioTable_reg[i] <= PRIO_CFG_RST;
      end
    end else if (prioWrite && isCfgNum(int'(prioExcNum))) begin
      prioTable_reg[prioExcNum] <= prioValue;
    end
  end

  // Pending and active sets
  logic [EXC_N-1:0] setMask;
  logic [EXC_N-1:0] takeMask;
  logic [EXC_N-1:0] retMask;
  logic [2:0]       prioCode [EXC_N];
  logic [2:0]       bestPrio;
  logic [NUM_W-1:0] bestNum;
  logic [2:0]       runPrio;
  logic [NUM_W-1:0] runNum;
  logic             bootDone_reg;

  always_comb begin
    setMask                            = '0;
    setMask[EXC_NMI]                   = nmiEdge || nmiSoftSet;
    setMask[EXC_HARD]                  = hardEvent;
    setMask[EXC_SVC]                   = svcExec;
    setMask[EXC_PENDED_SERVICE_EXCEPTION]                = pendSvSet;
    setMask[EXC_SYSTEM_TIMER_EXCEPTION]               = sysTickZero || sysTickSet;
    setMask[EXC_IRQ_BASE +: NUM_IRQ]   = irqEdge | irqSoftSet;
  end

  always_comb begin
    for (int i = 0; i < EXC_N; i++) begin
      prioCode[i] = (i == EXC_NMI)  ? PRIO_NMI  :
                    (i == EXC_HARD) ? PRIO_HARD :
                    isCfgNum(i)     ? 3'(PRIO_CFG_BASE + {1'b0, prioTable_reg[i]}) : PRIO_IDLE;
    end
  end

  // Descending scan with <= lets the lowest number win a tie
  always_comb begin
    bestPrio = PRIO_IDLE;
    bestNum  = '0;
    runPrio  = PRIO_IDLE;
    runNum   = '0;
    for (int i = EXC_N - 1; i >= 0; i--) begin
      if (excPend_reg[i] && prioCode[i] <= bestPrio) begin
        bestPrio = prioCode[i];
        bestNum  = NUM_W'(i);
      end
      if (excActive_reg[i] && prioCode[i] <= runPrio) begin
        runPrio = prioCode[i];
        runNum  = NUM_W'(i);
      end
    end
  end

  // Strictly higher needed, so equal priority never preempts
  wire take    = bootDone_reg && !excTake_reg && (bestPrio < runPrio);
  wire doRet   = excReturn && handlerMode_reg;

  always_comb begin
    takeMask = '0;
    retMask  = '0;
    takeMask[bestNum] = take;
    retMask[runNum]   = doRet;
  end

  // Set wins over the clear taken on entry, giving active and pending
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      excPend_reg     <= '0;
      excActive_reg   <= '0;
      handlerMode_reg <= 1'b0;
      bootDone_reg    <= 1'b0;
      bootFetch_reg   <= 1'b0;
      excTake_reg     <= 1'b0;
      excNum_reg      <= '0;
      excVector_reg   <= VECTOR_BASE;
    end else begin
      excPend_reg     <= (excPend_reg & ~takeMask) | setMask;
      excActive_reg   <= (excActive_reg & ~retMask) | takeMask;
      handlerMode_reg <= |((excActive_reg & ~retMask) | takeMask);
      bootDone_reg    <= 1'b1;
      bootFetch_reg   <= !bootDone_reg;
      excTake_reg     <= take;
      if (!bootDone_reg) begin
        excNum_reg    <= NUM_W'(EXC_RESET);
        excVector_reg <= RESET_VEC;
      end else if (take) begin
        excNum_reg    <= bestNum;
        excVector_reg <= vecOf(bestNum);
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_irq1_rise;
    $rose(irqIn[1]) ##1 irqIn[1] [*2];
  endsequence

  sequence s_dsb_busy;
    barrierDsb && (outCnt_next != '0);
  endsequence

  a_xn_fetch_refused: assert property (fetchXn |=> fetchRefused_reg && excPend_reg[EXC_HARD])
    else $error("execute-never fetch not refused with hard fault");
  a_exec_regions: assert property (fetchValid && fetchAddr[31:29] == 3'h0 |=> !fetchRefused_reg)
    else $error("code region fetch refused");
  a_narrow_ppr: assert property (narrowPpr && !dataBusy |=> dataRefused_reg && !dataIssue_reg)
    else $error("narrow private region access issued");
  a_strong_order: assert property (issue && isStrong |-> outCnt_reg == '0 && !strongOut_reg)
    else $error("strongly ordered access overtook another");
  a_dmb_holds: assert property (barrierDmb && outCnt_next != '0 |=> !issue)
    else $error("issue during data memory barrier");
  a_dsb_stall: assert property (s_dsb_busy |=> pipeStall_reg)
    else $error("data sync barrier did not stall");
  a_isb_refetch: assert property (barrierIsb |=> refetch_reg)
    else $error("no refetch after instruction barrier");
  a_lane_le: assert property (issue && dataSize == SIZE_BYTE |=> dataByteEn_reg == 4'(4'h1 << dataAddrOut_reg[1:0]))
    else $error("byte lane not little-endian");
  a_irq_pend: assert property (s_irq1_rise |-> ##[1:2]
    (excPend_reg[EXC_IRQ_BASE + 1] || excActive_reg[EXC_IRQ_BASE + 1]))
    else $error("interrupt request not pended");
  a_nested_active: assert property (excTake_reg && $past(handlerMode_reg) |-> $countones(excActive_reg) >= 2)
    else $error("preempted handler lost active state");
  a_vector_addr: assert property (excTake_reg |-> excVector_reg == 32'(excNum_reg) * 4)
    else $error("vector address not four times number");
  a_reserved_idle: assert property (excPend_reg[10:4] == '0 && excPend_reg[13:12] == '0)
    else $error("reserved exception pended");
  a_boot_vector: assert property ($rose(bootFetch_reg) |-> excVector_reg == RESET_VEC && !handlerMode_reg)
    else $error("reset restart vector wrong");
  a_nmi_wins: assert property (take && excPend_reg[EXC_NMI] |-> bestNum == NUM_W'(EXC_NMI))
    else $error("pending nmi not taken first");

endmodule

// [esr_exception_unit_bench.sv]
// Self-checking testbench for the exception state and region attribute unit
module esr_exception_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import esr_pkg::*;

  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        fetchValid = 1'b0, dataReq = 1'b0, dataWrite = 1'b0, dataDone;
  logic        barrierDmb = 1'b0, barrierDsb = 1'b0, barrierIsb = 1'b0, busStall = 1'b0;
  logic        nmiIn = 1'b0, nmiSoftSet = 1'b0, errorEvent = 1'b0, svcExec = 1'b0;
  logic        pendSvSet = 1'b0, sysTickZero = 1'b0, sysTickSet = 1'b0;
  logic        excReturn = 1'b0, prioWrite = 1'b0, ok;
  logic [31:0] fetchAddr = '0, dataAddr = '0, dataWdata = '0, irqIn = '0, irqSoftSet = '0;
  logic [1:0]  dataSize = 2'h0, prioValue = 2'h0;
  logic [5:0]  prioExcNum = 6'h0;
  logic        fetchRefused_reg, dataIssue_reg, dataRefused_reg, dataWriteOut_reg;
  logic        pipeStall_reg, refetch_reg, bootFetch_reg, excTake_reg, handlerMode_reg;
  logic [31:0] dataAddrOut_reg, dataLaneData_reg, excVector_reg;
  logic [3:0]  dataByteEn_reg;
  logic [5:0]  excNum_reg;
  logic [47:0] excPend_reg, excActive_reg;
  int          n_errors = 0;
  int          total_checks = 0;

  always #12.5 core_clk = ~core_clk;

  esr_exception_unit i_dut (
    .core_clk, .reset_n, .fetchValid, .fetchAddr, .fetchRefused_reg, .dataReq, .dataAddr,
    .dataSize, .dataWrite, .dataWdata, .dataDone, .dataIssue_reg, .dataRefused_reg,
    .dataAddrOut_reg, .dataByteEn_reg, .dataLaneData_reg, .dataWriteOut_reg, .barrierDmb,
    .barrierDsb, .barrierIsb, .pipeStall_reg, .refetch_reg, .irqIn, .irqSoftSet, .nmiIn,
    .nmiSoftSet, .errorEvent, .svcExec, .pendSvSet, .sysTickZero, .sysTickSet, .excReturn,
    .prioWrite, .prioExcNum, .prioValue, .bootFetch_reg, .excTake_reg, .excNum_reg,
    .excVector_reg, .handlerMode_reg, .excPend_reg, .excActive_reg
  );

  esr_bus_partner #(.LAT(3)) i_bus (
    .core_clk(core_clk), .reset_n(reset_n), .issue(dataIssue_reg), .stall(busStall), .done(dataDone)
  );

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_take(input int num);
    int k;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (excTake_reg !== 1'b1 && k < 20);
    chk("take", 1, excTake_reg);
    chk("exc number", num, excNum_reg);
    chk("vector", num * 4, excVector_reg);
    chk("active bit", 1, excActive_reg[num]);
  endtask

  task automatic ret;
    @(posedge core_clk) excReturn <= 1'b1;
    @(posedge core_clk) excReturn <= 1'b0;
    @(negedge core_clk);
  endtask

  // Holds the request until issued or refused, then drops it on the next edge
  task automatic data_req(input logic [31:0] a, input logic [1:0] sz, input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    dataReq <= 1'b1;
    dataAddr <= a;
    dataSize <= sz;
    dataWdata <= wd;
    dataWrite <= ~a[4];
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (dataIssue_reg !== 1'b1 && dataRefused_reg !== 1'b1 && k < 40);
    ok = (dataIssue_reg === 1'b1);
    @(posedge core_clk) dataReq <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge core_clk) reset_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk("pending in reset", 0, excPend_reg);
    chk("vector in reset", 0, excVector_reg);
    reset_n <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("boot fetch", 1, bootFetch_reg);
    chk("boot vector", 32'h4, excVector_reg);
    chk("boot number", 1, excNum_reg);
    chk("thread mode", 0, handlerMode_reg);
    $display("reset test finished");
  endtask

  task automatic t_fetch;
    logic [31:0] adr [12] = '{32'h0, 32'h1fff_ffff, 32'h2000_0000, 32'h3fff_ffff, 32'h4000_0000,
      32'h5fff_ffff, 32'h6000_0000, 32'h9fff_ffff, 32'ha000_0000, 32'hdfff_ffff, 32'he000_0000,
      32'he010_0000};
    logic [11:0] xn = 12'b1111_0011_0000;
    for (int i = 0; i <= 12; i++) begin
      @(posedge core_clk);
      fetchValid <= (i < 12);
      fetchAddr <= adr[i % 12];
      @(negedge core_clk);
      if (i > 0) chk("fetch refused", xn[i-1], fetchRefused_reg);
    end
    chk("fault number", 3, excNum_reg);
    chk("fault vector", 32'hc, excVector_reg);
    chk("fault active and pending", 2'b11, {excActive_reg[3], excPend_reg[3]});
    ret();
    wait_take(3);
    ret();
    chk("back to thread", 0, handlerMode_reg);
    $display("fetch test finished");
  endtask

  task automatic t_lanes;
    logic [31:0] a [4] = '{32'h2000_0001, 32'h2000_0002, 32'h2000_0004, 32'h2000_0003};
    logic [1:0]  sz [4] = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_BYTE};
    logic [31:0] wd [4] = '{32'ha5, 32'h1234, 32'h1122_3344, 32'h7e};
    logic [3:0]  be [4] = '{4'h2, 4'hc, 4'hf, 4'h8};
    logic [31:0] ld [4] = '{32'ha500, 32'h1234_0000, 32'h1122_3344, 32'h7e00_0000};
    for (int i = 0; i < 4; i++) begin
      data_req(a[i], sz[i], wd[i]);
      chk("issued", 1, ok);
      chk("byte enables", be[i], dataByteEn_reg);
      chk("lane data", ld[i], dataLaneData_reg);
      chk("issued address", a[i], dataAddrOut_reg);
      chk("write flag", 1, dataWriteOut_reg);
    end
    data_req(32'he000_e100, SIZE_BYTE, 32'h1);
    chk("narrow refused", 0, ok);
    wait_take(3);
    ret();
    data_req(32'he000_e100, SIZE_WORD, 32'h1);
    chk("word accepted", 1, ok);
    $display("lane test finished");
  endtask

  // A second request behind a stalled first one; hold says whether it must wait
  task automatic t_order(input logic [31:0] second, input bit useDmb, input bit hold);
    int k;
    // Let earlier transactions drain so only the stalled one is outstanding
    repeat (16) @(posedge core_clk);
    busStall <= 1'b1;
    data_req(32'h2000_0010, SIZE_WORD, 32'h0);
    chk("first issued", 1, ok);
    barrierDmb <= useDmb;
    @(posedge core_clk);
    barrierDmb <= 1'b0;
    dataReq <= 1'b1;
    dataAddr <= second;
    dataSize <= SIZE_WORD;
    for (k = 0; k < 6; k++) begin
      @(negedge core_clk);
      if (dataIssue_reg === 1'b1) break;
    end
    chk("cycles to issue", hold ? 6 : 1, k);
    @(posedge core_clk);
    busStall <= 1'b0;
    if (!hold) dataReq <= 1'b0;
    for (k = 0; k < 20 && hold; k++) begin
      @(negedge core_clk);
      if (dataIssue_reg === 1'b1) break;
    end
    chk("late issue address", second, dataAddrOut_reg);
    @(posedge core_clk) dataReq <= 1'b0;
    $display("order test finished");
  endtask

  task automatic t_barrier;
    int k;
    repeat (16) @(posedge core_clk);
    busStall <= 1'b1;
    data_req(32'h2000_0030, SIZE_WORD, 32'h0);
    chk("barrier access issued", 1, ok);
    barrierDsb <= 1'b1;
    @(posedge core_clk) barrierDsb <= 1'b0;
    repeat (5) begin
      @(negedge core_clk);
      chk("stall held", 1, pipeStall_reg);
    end
    @(posedge core_clk) busStall <= 1'b0;
    for (k = 0; k < 20 && pipeStall_reg !== 1'b0; k++) @(negedge core_clk);
    chk("stall released", 0, pipeStall_reg);
    @(posedge core_clk) barrierIsb <= 1'b1;
    @(posedge core_clk) barrierIsb <= 1'b0;
    @(negedge core_clk);
    chk("refetch", 1, refetch_reg);
    @(negedge core_clk);
    chk("refetch pulse", 0, refetch_reg);
    $display("barrier test finished");
  endtask

  task automatic t_nest;
    @(posedge core_clk) svcExec <= 1'b1;
    @(posedge core_clk) svcExec <= 1'b0;
    wait_take(EXC_SVC);
    @(posedge core_clk);
    svcExec <= 1'b1;
    pendSvSet <= 1'b1;
    @(posedge core_clk);
    svcExec <= 1'b0;
    pendSvSet <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("equal priority waits", 2'b10, {excPend_reg[14], excActive_reg[14]});
    chk("active and pending", 2'b11, {excPend_reg[11], excActive_reg[11]});
    @(posedge core_clk) nmiSoftSet <= 1'b1;
    @(posedge core_clk) nmiSoftSet <= 1'b0;
    wait_take(EXC_NMI);
    chk("both active", 1, excActive_reg[11]);
    ret();
    chk("nmi retired", 2'b01, {excActive_reg[2], excActive_reg[11]});
    ret();
    wait_take(EXC_SVC);
    ret();
    wait_take(EXC_PENDED_SERVICE_EXCEPTION);
    ret();
    chk("thread again", 0, handlerMode_reg);
    $display("nesting test finished");
  endtask

  task automatic t_prio;
    @(posedge core_clk) irqIn[1] <= 1'b1;
    wait_take(17);
    ret();
    @(posedge core_clk);
    irqIn[1] <= 1'b0;
    prioWrite <= 1'b1;
    prioExcNum <= 6'h0f;
    prioValue <= 2'h2;
    @(posedge core_clk);
    prioWrite <= 1'b0;
    sysTickSet <= 1'b1;
    irqSoftSet[0] <= 1'b1;
    @(posedge core_clk);
    sysTickSet <= 1'b0;
    irqSoftSet[0] <= 1'b0;
    wait_take(EXC_IRQ_BASE);
    chk("timer pending", 1, excPend_reg[15]);
    ret();
    wait_take(EXC_SYSTEM_TIMER_EXCEPTION);
    ret();
    // Error and timer zero together, then the nmi pin preempts the fault
    @(posedge core_clk);
    nmiIn <= 1'b1;
    errorEvent <= 1'b1;
    sysTickZero <= 1'b1;
    @(posedge core_clk);
    errorEvent <= 1'b0;
    sysTickZero <= 1'b0;
    wait_take(EXC_HARD);
    wait_take(EXC_NMI);
    ret();
    ret();
    wait_take(EXC_SYSTEM_TIMER_EXCEPTION);
    ret();
    @(posedge core_clk) nmiIn <= 1'b0;
    $display("priority test finished");
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end

  initial begin
    do_reset();
    t_fetch();
    t_lanes();
    t_order(32'h2000_0020, 1'b0, 1'b0);
    t_order(32'h2000_0040, 1'b1, 1'b1);
    t_order(32'he000_e010, 1'b0, 1'b1);
    t_barrier();
    t_nest();
    t_prio();
    @(posedge core_clk) svcExec <= 1'b1;
    @(posedge core_clk) svcExec <= 1'b0;
    do_reset();
    finish_test();
  end
endmodule

// [esr_pkg.sv]
// Shared constants and types for the exception state and region attribute unit
package esr_pkg;

  // Region bases; the address is matched against these from the top down
  localparam logic [31:0] CODE_BASE   = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE   = 32'h2000_0000;
  localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] XRAM_BASE   = 32'h6000_0000;
  localparam logic [31:0] XDEV_BASE   = 32'ha000_0000;
  localparam logic [31:0] PPR_BASE    = 32'he000_0000;
  localparam logic [31:0] PPR_LAST    = 32'he00f_ffff;

  typedef enum logic [2:0] {
    REG_CODE   = 3'h0,
    REG_SRAM   = 3'h1,
    REG_PERIPH = 3'h2,
    REG_XRAM   = 3'h3,
    REG_XDEV   = 3'h4,
    REG_PPR    = 3'h5,
    REG_VENDOR = 3'h6
  } esr_region_t;

  typedef enum logic [1:0] {
    MEM_NORMAL = 2'h0,
    MEM_DEVICE = 2'h1,
    MEM_STRONG = 2'h2
  } esr_memtype_t;

  // Access sizes from the pipeline
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Exception numbers
  localparam int EXC_RESET    = 1;
  localparam int EXC_NMI      = 2;
  localparam int EXC_HARD     = 3;
  localparam int EXC_SVC      = 11;
  localparam int EXC_PENDED_SERVICE_EXCEPTION   = 14;
  localparam int EXC_SYSTEM_TIMER_EXCEPTION  = 15;
  localparam int EXC_IRQ_BASE = 16;

  // Priority codes: documented value plus three, so -3 maps to 0
  localparam logic [2:0] PRIO_RESET    = 3'h0;
  localparam logic [2:0] PRIO_NMI      = 3'h1;
  localparam logic [2:0] PRIO_HARD     = 3'h2;
  localparam logic [2:0] PRIO_CFG_BASE = 3'h3;
  localparam logic [2:0] PRIO_IDLE     = 3'h7;
  localparam logic [1:0] PRIO_CFG_RST  = 2'h0;

  localparam logic [31:0] VECTOR_BASE = 32'h0000_0000;
  localparam logic [31:0] RESET_VEC   = 32'h0000_0004;

endpackage

// [esr_region_decode.sv]
// Address to region, memory type and execute-never decoder
module esr_region_decode
  import esr_pkg::*;
(
  // Address in
  input  wire logic [31:0] addr,
  // Attributes out
  output esr_region_t      region,
  output esr_memtype_t     memType,
  output logic             execNever
);

  assign region = (addr >= PPR_BASE && addr <= PPR_LAST) ? REG_PPR    :
                  (addr >  PPR_LAST)                      ? REG_VENDOR :
                  (addr >= XDEV_BASE)                     ? REG_XDEV   :
                  (addr >= XRAM_BASE)                     ? REG_XRAM   :
                  (addr >= PERIPH_BASE)                   ? REG_PERIPH :
                  (addr >= SRAM_BASE)                     ? REG_SRAM   : REG_CODE;

  assign memType = (region == REG_PPR) ? MEM_STRONG :
                   (region == REG_CODE || region == REG_SRAM || region == REG_XRAM) ? MEM_NORMAL :
                   MEM_DEVICE;

  // Only the three program-capable regions may be fetched from
  assign execNever = !(region == REG_CODE || region == REG_SRAM || region == REG_XRAM);

endmodule
